// ### include/card16_pkg.sv
// Constants, register map and pin bundle of the 16-bit socket
// event and control block.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz system clock.
package card16_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IRQ_LINES = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_GEN_CTL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EVT_LATCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EVT_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IF_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SOCK_EVT = 8'h10;

    // Decoded register selection
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_GEN_CTL = 3'h1;
    localparam logic [2:0] SEL_EVT_LATCH = 3'h2;
    localparam logic [2:0] SEL_EVT_CFG = 3'h3;
    localparam logic [2:0] SEL_IF_STATUS = 3'h4;
    localparam logic [2:0] SEL_SOCK_EVT = 3'h5;

    // General control fields
    localparam int GC_RING_BIT = 7;
    localparam int GC_RESET_BIT = 6;
    localparam int GC_KIND_BIT = 5;
    localparam int GC_SPARE_BIT = 4;
    localparam int GC_ROUTE_LSB = 0;
    localparam int GC_ROUTE_W = 4;
    localparam logic [7:0] GEN_CTL_RESET = 8'h00;

    // Event latch and enable fields
    localparam int EV_DETECT = 3;
    localparam int EV_READY = 2;
    localparam int EV_WARN = 1;
    localparam int EV_DEAD = 0;
    localparam int EV_W = 4;
    localparam logic [EV_W-1:0] EVT_LATCH_RESET = 4'h0;

    // Event configuration fields
    localparam int CFG_EN_LSB = 0;
    localparam int CFG_ACK_BIT = 4;
    localparam int CFG_ROUTE_EN_BIT = 5;
    localparam logic [7:0] EVT_CFG_RESET = 8'h00;

    // Socket event detect flags
    localparam int SE_DETECT_A = 0;
    localparam int SE_DETECT_B = 1;
    localparam logic [1:0] SOCK_EVT_RESET = 2'h0;

    // Interface status fields
    localparam int IS_BATT_FIRST = 0;
    localparam int IS_BATT_SECOND = 1;
    localparam int IS_DETECT_A = 2;
    localparam int IS_DETECT_B = 3;
    localparam int IS_READY = 5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Card pins as seen at the socket, before synchronisation
    typedef struct packed {
        logic detect_input_a_n;
        logic detect_input_b_n;
        logic card_ready_busy_input;
        logic battery_detect_first;
        logic battery_detect_second;
        logic status_change_ring_input_n;
        logic card_irq_input_n;
    } card_pins_t;

    localparam int PIN_W = $bits(card_pins_t);
    localparam logic [PIN_W-1:0] PINS_IDLE = 7'h7F;

endpackage

// ### rtl/pin_sync.sv
// Two-flop synchroniser for a bundle of socket pins.
// Assumes the pins are asynchronous to clk_i.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                begin
                    meta[i] <= IDLE[i];
                    q_o[i] <= IDLE[i];
                end
                else
                begin
                    meta[i] <= d_i[i];
                    q_o[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule

// ### rtl/card16_interrupt_status_ctrl.sv
// Socket interrupt and general control plus socket event latch,
// reached over AXI4-Lite.
// Assumes card pins are asynchronous and software services events.
`timescale 1ns/100ps

module card16_interrupt_status_ctrl (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [card16_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [card16_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [card16_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [card16_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input card16_pkg::card_pins_t pins_i,
    output logic ring_out_pin_n_o,
    output logic card_reset_o,
    output logic [card16_pkg::IRQ_LINES-1:0] sys_irq_o,
    output logic csc_irq_o
);
    import card16_pkg::*;

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [2:0] s;
        s = SEL_NONE;
        if (a == OFS_GEN_CTL)
            s = SEL_GEN_CTL;
        else if (a == OFS_EVT_LATCH)
            s = SEL_EVT_LATCH;
        else if (a == OFS_EVT_CFG)
            s = SEL_EVT_CFG;
        else if (a == OFS_IF_STATUS)
            s = SEL_IF_STATUS;
        else if (a == OFS_SOCK_EVT)
            s = SEL_SOCK_EVT;
        return s;
    endfunction

    // Synchronised pins and their previous sample
    card_pins_t pins_s;
    card_pins_t pins_q;

    pin_sync #(
        .WIDTH(PIN_W),
        .IDLE(PINS_IDLE)
    ) u_pin_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .d_i(pins_i),
        .q_o(pins_s)
    );

    // Registers
    logic [7:0] socket_interrupt_general_control;
    logic [EV_W-1:0] socket_event_latch;
    logic [7:0] event_config;
    logic [1:0] socket_event_detect;

    // Bus holding state
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;

    // Control fields
    wire ring_pass_through_sel = socket_interrupt_general_control[GC_RING_BIT];
    wire socket_reset_ctl = socket_interrupt_general_control[GC_RESET_BIT];
    wire socket_interface_kind = socket_interrupt_general_control[GC_KIND_BIT];
    wire [GC_ROUTE_W-1:0] card_irq_route_sel =
        socket_interrupt_general_control[GC_ROUTE_LSB +: GC_ROUTE_W];
    wire [EV_W-1:0] event_en = event_config[CFG_EN_LSB +: EV_W];
    wire ack_mode = event_config[CFG_ACK_BIT];
    wire bridge_legacy_irq_route_en = event_config[CFG_ROUTE_EN_BIT];

    wire io_mode = socket_interface_kind;
    // Ring select counts only for the I/O interface
    wire ring_on = io_mode & ring_pass_through_sel;

    // Battery decode
    wire batt_dead = ~pins_s.battery_detect_first;
    wire batt_warn = pins_s.battery_detect_first
                     & ~pins_s.battery_detect_second;
    wire batt_dead_q = ~pins_q.battery_detect_first;
    wire batt_warn_q = pins_q.battery_detect_first
                       & ~pins_q.battery_detect_second;

    // Raw event sources
    wire detect_a_chg = pins_s.detect_input_a_n ^ pins_q.detect_input_a_n;
    wire detect_b_chg = pins_s.detect_input_b_n ^ pins_q.detect_input_b_n;
    wire ev_detect = detect_a_chg | detect_b_chg;
    wire ev_ready = ~io_mode & pins_s.card_ready_busy_input
                    & ~pins_q.card_ready_busy_input;
    // Warning entry, memory only
    wire ev_warn = ~io_mode & batt_warn & ~batt_warn_q;
    // Status input falling edge in I/O, dead entry in memory
    wire status_fall = ~pins_s.status_change_ring_input_n
                       & pins_q.status_change_ring_input_n;
    wire ev_dead = io_mode ? (~ring_on & status_fall)
                           : (batt_dead & ~batt_dead_q);

    // Bits that may hold a value
    wire [EV_W-1:0] keep_mask = {event_en[EV_DETECT],
                                 event_en[EV_READY] & ~io_mode,
                                 event_en[EV_WARN] & ~io_mode,
                                 event_en[EV_DEAD] & ~ring_on};
    wire [EV_W-1:0] ev_set = {ev_detect, ev_ready, ev_warn, ev_dead}
                             & keep_mask;

    // Write channel decode
    wire wr_fire = aw_have & w_have & ~s_axi_bvalid_o;
    wire [2:0] wr_sel = reg_sel(aw_addr);
    wire wr_ok = wr_sel != SEL_NONE;
    wire wr_lane = wr_fire & w_lane;
    wire we_gen = wr_lane & (wr_sel == SEL_GEN_CTL);
    wire we_cfg = wr_lane & (wr_sel == SEL_EVT_CFG);
    wire we_latch = wr_lane & (wr_sel == SEL_EVT_LATCH) & ack_mode;
    wire we_sock = wr_lane & (wr_sel == SEL_SOCK_EVT) & ack_mode;

    // Read channel decode
    wire rd_fire = s_axi_arvalid_i & s_axi_arready_o;
    wire [2:0] rd_sel = reg_sel(s_axi_araddr_i);
    wire rd_clear = rd_fire & ~ack_mode;
    wire rc_latch = rd_clear & (rd_sel == SEL_EVT_LATCH);
    wire rc_sock = rd_clear & (rd_sel == SEL_SOCK_EVT);

    // Write-one clear of latch bits
    wire [EV_W-1:0] w1c_latch = we_latch ? w_byte[EV_W-1:0] : EVT_LATCH_RESET;
    wire [1:0] w1c_sock = we_sock ? w_byte[1:0] : SOCK_EVT_RESET;
    // Detect flags cleared by write also clear bit 3
    wire sock_w1c_any = |(w1c_sock & socket_event_detect);
    wire [EV_W-1:0] ev_clear = rc_latch ? ~EVT_LATCH_RESET
                               : (w1c_latch | {sock_w1c_any, 3'h0});
    // Set wins over a clear in the same cycle
    wire [EV_W-1:0] next_latch = ((socket_event_latch & ~ev_clear) | ev_set)
                                 & keep_mask;

    wire [1:0] sock_set = {detect_b_chg, detect_a_chg};
    wire [1:0] sock_clear = rc_sock ? ~SOCK_EVT_RESET : w1c_sock;
    wire [1:0] next_sock = (socket_event_detect & ~sock_clear) | sock_set;

    // Interface status view
    wire status_bit0 = (io_mode & ~ring_pass_through_sel)
                       ? pins_s.status_change_ring_input_n
                       : pins_s.battery_detect_first;
    wire [7:0] if_status = {2'h0,
                            pins_s.card_ready_busy_input & ~io_mode,
                            1'h0,
                            ~pins_s.detect_input_b_n,
                            ~pins_s.detect_input_a_n,
                            pins_s.battery_detect_second,
                            status_bit0};

    // Read data; upper latch bits read zero
    wire [7:0] rd_byte =
        (rd_sel == SEL_GEN_CTL) ? socket_interrupt_general_control :
        (rd_sel == SEL_EVT_LATCH) ? {4'h0, socket_event_latch & keep_mask} :
        (rd_sel == SEL_EVT_CFG) ? event_config :
        (rd_sel == SEL_IF_STATUS) ? if_status :
        (rd_sel == SEL_SOCK_EVT) ? {6'h00, socket_event_detect} :
        8'h00;
    wire rd_ok = rd_sel != SEL_NONE;

    // Card irq steering, value zero stays unrouted
    wire route_on = io_mode & bridge_legacy_irq_route_en
                    & (card_irq_route_sel != 4'h0);
    wire [IRQ_LINES-1:0] route_onehot =
        IRQ_LINES'(16'h0001 << card_irq_route_sel);
    wire [IRQ_LINES-1:0] next_sys_irq =
        (route_on & ~pins_s.card_irq_input_n) ? route_onehot : 16'h0000;

    // Ring forwarding
    wire next_ring_n = ring_on ? pins_s.status_change_ring_input_n : 1'b1;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            pins_q <= PINS_IDLE;
        else
            pins_q <= pins_s;
    end

    // Control register; spare bit is plain storage
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            socket_interrupt_general_control <= GEN_CTL_RESET;
        else if (we_gen)
            socket_interrupt_general_control <= w_byte;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            event_config <= EVT_CFG_RESET;
        else if (we_cfg)
            event_config <= w_byte;
    end

    // Event latch; further events only accumulate
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            socket_event_latch <= EVT_LATCH_RESET;
        else
            socket_event_latch <= next_latch;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            socket_event_detect <= SOCK_EVT_RESET;
        else
            socket_event_detect <= next_sock;
    end

    // Socket outputs
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ring_out_pin_n_o <= 1'b1;
            card_reset_o <= 1'b1;
            sys_irq_o <= 16'h0000;
            csc_irq_o <= 1'b0;
        end
        else
        begin
            ring_out_pin_n_o <= next_ring_n;
            card_reset_o <= ~socket_reset_ctl;
            sys_irq_o <= next_sys_irq;
            // Level held while any bit stands
            csc_irq_o <= |next_latch;
        end
    end

    // Write address and data capture, in either order
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            aw_have <= 1'b0;
            s_axi_awready_o <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (s_axi_awvalid_i & s_axi_awready_o)
        begin
            aw_have <= 1'b1;
            s_axi_awready_o <= 1'b0;
            aw_addr <= s_axi_awaddr_i;
        end
        else if (wr_fire)
            aw_have <= 1'b0;
        else
            s_axi_awready_o <= ~aw_have & ~s_axi_bvalid_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            w_have <= 1'b0;
            s_axi_wready_o <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end
        else if (s_axi_wvalid_i & s_axi_wready_o)
        begin
            w_have <= 1'b1;
            s_axi_wready_o <= 1'b0;
            w_byte <= s_axi_wdata_i[7:0];
            w_lane <= s_axi_wstrb_i[0];
        end
        else if (wr_fire)
            w_have <= 1'b0;
        else
            s_axi_wready_o <= ~w_have & ~s_axi_bvalid_o;
    end

    // Write response
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
    end

    // Read channel, one read at a time
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {24'h000000, rd_byte};
            s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid_o)
        begin
            if (s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
        else
            s_axi_arready_o <= 1'b1;
    end

endmodule

// ### verif/card16_card_model.sv
// Card seated in the socket: drives the pin levels the bench asks for.
// Assumes pin edges are unrelated to the block clock.
`timescale 1ns/100ps
module card16_card_model (
    input wire card16_pkg::card_pins_t want_i,
    output card16_pkg::card_pins_t pins_o
);
    // Pins move mid-cycle, apart from the clock
    assign #1.3 pins_o = want_i;
endmodule

// ### verif/card16_ctl_asserts.sv
// Port checker for the socket control and event block.
// Assumes it is bound to the block top on the one system clock.
`timescale 1ns/100ps
module card16_ctl_asserts (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [card16_pkg::DATA_W-1:0] s_axi_rdata_o,
    input wire card16_pkg::card_pins_t pins_i,
    input wire logic ring_out_pin_n_o,
    input wire logic card_reset_o,
    input wire logic [card16_pkg::IRQ_LINES-1:0] sys_irq_o,
    input wire logic csc_irq_o
);
    import card16_pkg::*;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o
        && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
        else $error("write answer not on time");
    a_write_refuse: assert property (s_axi_bvalid_o
        |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while answer pending");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o) else $error("read answer not on time");
    a_read_upper: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_ring_cause: assert property (
        !ring_out_pin_n_o |-> !$past(pins_i.status_change_ring_input_n, 3))
        else $error("ring out low without ring input");
    a_irq_onehot: assert property (
        $onehot0(sys_irq_o) && !sys_irq_o[0])
        else $error("system irq lines not one-hot");
    a_irq_cause: assert property (
        |sys_irq_o |-> !$past(pins_i.card_irq_input_n, 3))
        else $error("system irq without card request");
    a_reset_write: assert property (
        $changed(card_reset_o) |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
        else $error("card reset moved without write");
    a_csc_clear: assert property (
        $fell(csc_irq_o) |-> $past(s_axi_arvalid_i && s_axi_arready_o)
        || s_axi_bvalid_o || $past(s_axi_bvalid_o))
        else $error("event irq dropped without access");
endmodule
bind card16_interrupt_status_ctrl card16_ctl_asserts u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rdata_o(s_axi_rdata_o),
    .pins_i(pins_i), .ring_out_pin_n_o(ring_out_pin_n_o),
    .card_reset_o(card_reset_o), .sys_irq_o(sys_irq_o),
    .csc_irq_o(csc_irq_o));

// ### verif/card16_interrupt_status_ctrl_test.sv
// Self-checking bench for the socket control and event block.
// Assumes the card model on the pins and an AXI4-Lite master here.
`timescale 1ns/100ps
module card16_interrupt_status_ctrl_test;
    import card16_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ring_n, card_rst, csc;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, data;
    logic [15:0] sys_irq;
    card_pins_t want = PINS_IDLE;
    card_pins_t pins;
    int n_errors = 0;
    int num_checks = 0;
    always #2 clk_i = ~clk_i;
    card16_interrupt_status_ctrl DUT (
        .clk_i(clk_i), .reset_i(reset_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(1'b1), .pins_i(pins),
        .ring_out_pin_n_o(ring_n), .card_reset_o(card_rst),
        .sys_irq_o(sys_irq), .csc_irq_o(csc));
    card16_card_model u_card (.want_i(want), .pins_o(pins));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ck(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic lim(input int n);
        if (n >= 200)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask
    task automatic wt(ref logic s);
        int n;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk_i);
            if (s === 1'b1)
                break;
        end
        lim(n);
    endtask
    task automatic wr(input logic [7:0] a, d);
        int n;
        bit ad = 0;
        bit wd = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 200 && !(ad && wd); n++)
        begin
            @(posedge clk_i);
            ad = ad || awready === 1'b1;
            wd = wd || wready === 1'b1;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        lim(n);
        wt(bvalid);
        resp = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wt(arready);
        arvalid <= 1'b0;
        wt(rvalid);
        data = rdata;
        resp = rresp;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, e);
        rd(a);
        ck(nm, data, {24'h000000, e});
    endtask
    task automatic st();
        repeat (6) @(posedge clk_i);
    endtask
    task automatic s_reset();
        rc("gen", OFS_GEN_CTL, GEN_CTL_RESET);
        ck("card_reset", card_rst, 1'b1);
        want.detect_input_a_n <= 1'b0;
        want.battery_detect_first <= 1'b0;
        st();
        wr(OFS_EVT_LATCH, 8'hF0);
        rc("latch off", OFS_EVT_LATCH, 8'h00);
        ck("csc off", csc, 1'b0);
        want <= PINS_IDLE;
        st();
        rd(8'h14);
        ck("rresp", resp, RESP_SLVERR);
        wr(8'h14, 8'hFF);
        ck("bresp", resp, RESP_SLVERR);
        rd(OFS_SOCK_EVT);
    endtask
    task automatic s_ctl();
        wr(OFS_GEN_CTL, 8'h50);
        rc("gen", OFS_GEN_CTL, 8'h50);
        ck("card_reset", card_rst, 1'b0);
        wstrb <= 4'hE;
        wr(OFS_GEN_CTL, 8'h00);
        wstrb <= 4'hF;
        ck("lane bresp", resp, RESP_OKAY);
        rc("gen lane", OFS_GEN_CTL, 8'h50);
        ck("card_reset lane", card_rst, 1'b0);
        wr(OFS_GEN_CTL, 8'h00);
        rc("gen", OFS_GEN_CTL, 8'h00);
        ck("card_reset", card_rst, 1'b1);
    endtask
    task automatic s_route();
        wr(OFS_EVT_CFG, 8'h20);
        want.card_irq_input_n <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            wr(OFS_GEN_CTL, 8'(8'h60 + i));
            st();
            ck("sys_irq", sys_irq, i == 0 ? 0 : 1 << i);
        end
        wr(OFS_GEN_CTL, 8'h45);
        st();
        ck("sys_irq mem", sys_irq, 0);
        wr(OFS_GEN_CTL, 8'h65);
        wr(OFS_EVT_CFG, 8'h00);
        st();
        ck("sys_irq off", sys_irq, 0);
        want.card_irq_input_n <= 1'b1;
    endtask
    task automatic s_ring();
        wr(OFS_EVT_CFG, 8'h0F);
        wr(OFS_GEN_CTL, 8'hE0);
        want.status_change_ring_input_n <= 1'b0;
        st();
        ck("ring", ring_n, 1'b0);
        rc("latch ring", OFS_EVT_LATCH, 8'h00);
        wr(OFS_GEN_CTL, 8'hC0);
        st();
        ck("ring mem", ring_n, 1'b1);
        want.status_change_ring_input_n <= 1'b1;
        wr(OFS_GEN_CTL, 8'h60);
        st();
        want.status_change_ring_input_n <= 1'b0;
        want.card_ready_busy_input <= 1'b0;
        st();
        want.card_ready_busy_input <= 1'b1;
        want.battery_detect_second <= 1'b0;
        st();
        ck("csc io", csc, 1'b1);
        rc("status io", OFS_IF_STATUS, 8'h00);
        rc("latch io", OFS_EVT_LATCH, 8'h01);
        ck("csc read", csc, 1'b0);
        want <= PINS_IDLE;
        st();
        rd(OFS_EVT_LATCH);
    endtask
    task automatic s_nack();
        wr(OFS_GEN_CTL, 8'h40);
        want.detect_input_a_n <= 1'b0;
        want.card_ready_busy_input <= 1'b0;
        st();
        want.card_ready_busy_input <= 1'b1;
        want.battery_detect_second <= 1'b0;
        st();
        want.battery_detect_first <= 1'b0;
        st();
        ck("csc held", csc, 1'b1);
        rc("latch all", OFS_EVT_LATCH, 8'h0F);
        ck("csc read", csc, 1'b0);
        rc("latch again", OFS_EVT_LATCH, 8'h00);
        rc("detect flag", OFS_SOCK_EVT, 8'h01);
        want <= PINS_IDLE;
        st();
        rc("latch detect", OFS_EVT_LATCH, 8'h08);
        rd(OFS_SOCK_EVT);
    endtask
    task automatic s_ack();
        wr(OFS_EVT_CFG, 8'h1F);
        want.detect_input_b_n <= 1'b0;
        want.card_ready_busy_input <= 1'b0;
        st();
        want.card_ready_busy_input <= 1'b1;
        st();
        rc("latch ack", OFS_EVT_LATCH, 8'h0C);
        wr(OFS_EVT_LATCH, 8'h04);
        rc("latch w1c", OFS_EVT_LATCH, 8'h08);
        ck("csc held", csc, 1'b1);
        rc("detect flag", OFS_SOCK_EVT, 8'h02);
        wr(OFS_SOCK_EVT, 8'h02);
        rc("latch flag", OFS_EVT_LATCH, 8'h00);
        ck("csc clear", csc, 1'b0);
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        s_reset();
        s_ctl();
        s_route();
        s_ring();
        s_nack();
        s_ack();
        report_and_stop();
    end
endmodule
